// [logic/cpw_map.vh]
`ifndef CPW_MAP_VH
`define CPW_MAP_VH

// Register byte offsets.
`define CPW_OFF_UNIT_CTRL 8'h00
`define CPW_OFF_DUTY_WRITE 8'h04
`define CPW_OFF_DUTY_SHADOW 8'h08
`define CPW_OFF_PERIPH_FLAGS 8'h0C
`define CPW_OFF_TIMER16_CTRL 8'h10
`define CPW_OFF_TIMER16_COUNT 8'h14
`define CPW_OFF_PERIOD 8'h18
`define CPW_OFF_TIMEBASE8_COUNT 8'h1C
`define CPW_OFF_TIMEBASE8_CTRL 8'h20
`define CPW_OFF_FLAG_CLEAR 8'h24
`define CPW_OFF_PERIPH_ENABLES 8'h8C

// Reset values.
`define CPW_RST_UNIT_CTRL 8'h00
`define CPW_RST_DUTY 8'h00
`define CPW_RST_PERIPH_FLAGS 8'h00
`define CPW_RST_PERIPH_ENABLES 8'h00
`define CPW_RST_TIMER16_CTRL 8'h00
`define CPW_RST_PERIOD 8'hFF
`define CPW_RST_TIMEBASE8_CTRL 8'h00

// Unit control fields and modes.
`define CPW_CTRL_MODE_MSB 3
`define CPW_CTRL_MODE_LSB 0
`define CPW_CTRL_DUTY_LO_MSB 5
`define CPW_CTRL_DUTY_LO_LSB 4
`define CPW_MODE_OFF 4'h0
`define CPW_MODE_CMP_SWI 4'hA
`define CPW_MODE_CMP_SPECIAL 4'hB
`define CPW_MODE_PWM_MSB2 2'h3

// Flag and enable register bits.
`define CPW_FLAG_TIMER16_OVF 0
`define CPW_FLAG_TIMEBASE8_MATCH 1
`define CPW_FLAG_UNIT_EVENT 2
`define CPW_FLAG_MASK 8'h07

// Timer16 control fields.
`define CPW_T16_ON 0
`define CPW_T16_EXT_SEL 1
`define CPW_T16_ASYNC 2
`define CPW_T16_PRE_MSB 5
`define CPW_T16_PRE_LSB 4
`define CPW_T16_CTRL_MASK 8'h37

// Timebase8 control fields.
`define CPW_TB_PRE_MSB 1
`define CPW_TB_PRE_LSB 0
`define CPW_TB_ON 2
`define CPW_TB_CTRL_MASK 8'h07

// Oscillator periods per instruction cycle.
`define CPW_OSC_PER_CYCLE 4

`endif

// [logic/cpw_timer16.v]
`timescale 1ns/1ps
`default_nettype none

// Sixteen-bit timer with 1/2/4/8 prescaler, software load and hardware clear.
module cpw_timer16 #(
   parameter WIDTH = 16
) (
   // Clock and reset.
   input wire i_clock,
   input wire i_resetn,
   // Count sources and control.
   input wire i_cycle_en,
   input wire i_ext_rise,
   input wire i_on,
   input wire i_ext_sel,
   input wire [1:0] i_prescale,
   // Hardware clear and software load.
   input wire i_clear,
   input wire i_wr_lo,
   input wire i_wr_hi,
   input wire [WIDTH-1:0] i_wdata,
   // State.
   output reg [WIDTH-1:0] o_count,
   output reg o_overflow
);

   reg [2:0] pre_q;
   reg clear_pend_q;
   wire src = i_ext_sel ? i_ext_rise : i_cycle_en;
   wire pre_done = (pre_q == ((3'h1 << i_prescale) - 3'h1));
   wire tick = i_on && src && pre_done;

   always @(posedge i_clock) begin
      if (!i_resetn) begin
         pre_q <= 3'h0;
         clear_pend_q <= 1'b0;
         o_count <= {WIDTH{1'b0}};
         o_overflow <= 1'b0;
      end else begin
         o_overflow <= 1'b0;
         if (i_on && src) begin
            pre_q <= pre_done ? 3'h0 : pre_q + 3'h1;
         end
         if (i_wr_lo || i_wr_hi) begin
            clear_pend_q <= 1'b0;
            if (i_wr_lo) begin
               o_count[7:0] <= i_wdata[7:0];
            end
            if (i_wr_hi) begin
               o_count[WIDTH-1:8] <= i_wdata[WIDTH-1:8];
            end
         end else if (tick && (i_clear || clear_pend_q)) begin
            // The trigger clear takes the place of an increment and never raises the overflow flag.
            o_count <= {WIDTH{1'b0}};
            clear_pend_q <= 1'b0;
         end else if (i_clear) begin
            clear_pend_q <= 1'b1;
         end else if (tick) begin
            o_count <= o_count + {{(WIDTH-1){1'b0}}, 1'b1};
            o_overflow <= &o_count;
         end
      end
   end

endmodule

`default_nettype wire

// [logic/cpw_timebase8.v]
`timescale 1ns/1ps
`default_nettype none

// Eight-bit period timebase; each increment spans four clocks times the prescale.
module cpw_timebase8 (
   // Clock and reset.
   input wire i_clock,
   input wire i_resetn,
   // Control.
   input wire i_on,
   input wire [1:0] i_prescale,
   input wire [7:0] i_period,
   input wire i_wr_count,
   input wire [7:0] i_wdata,
   // State.
   output reg [7:0] o_count,
   output reg [1:0] o_quarter,
   output wire o_rollover
);

   reg [5:0] fine_q;
   wire [5:0] fine_last = (i_prescale == 2'h0) ? 6'h03 : (i_prescale == 2'h1) ? 6'h0F : 6'h3F;
   wire inc = i_on && (fine_q == fine_last);

   assign o_rollover = inc && (o_count == i_period);

   always @* begin
      case (i_prescale)
         2'h0: o_quarter = fine_q[1:0];
         2'h1: o_quarter = fine_q[3:2];
         default: o_quarter = fine_q[5:4];
      endcase
   end

   always @(posedge i_clock) begin
      if (!i_resetn) begin
         fine_q <= 6'h00;
         o_count <= 8'h00;
      end else if (i_wr_count) begin
         o_count <= i_wdata;
         fine_q <= 6'h00;
      end else if (i_on) begin
         fine_q <= inc ? 6'h00 : fine_q + 6'h01;
         if (o_rollover) begin
            o_count <= 8'h00;
         end else if (inc) begin
            o_count <= o_count + 8'h01;
         end
      end
   end

endmodule

`default_nettype wire

// [logic/cpw_unit.v]
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

`include "cpw_map.vh"

// Operation
// - Software-interrupt compare: match only sets event flag, pin untouched.
// - Special-event compare: match pulses trigger, clears timer16, starts conversion.
// - Compare pair therefore acts as timer16 programmable period.
// - Trigger clear never sets the timer16 overflow flag.
// - PWM mode drives pin with up to ten-bit duty resolution.
// - Writing zero to unit control forces PWM latch low.
// - PWM period is (period+1) times four oscillator periods times prescale.
// - Timebase count equal to period clears on next increment.
// - Rollover sets pin high unless duty is zero.
// - Rollover copies written duty into read-only shadow.
// - Each cycle is high for duty time, then low.
module cpw_unit (
   // Clock and reset.
   input wire i_clock,
   input wire i_resetn,
   // Avalon-MM slave.
   input wire [7:0] i_address,
   input wire i_read,
   input wire i_write,
   input wire [3:0] i_byteenable,
   input wire [31:0] i_writedata,
   output reg [31:0] o_readdata,
   output reg o_waitrequest,
   // Timer16 external count pin.
   input wire i_t16_ext_clk,
   // Unit pin, conversion start and interrupt.
   output reg o_unit_pin,
   output reg o_adc_start,
   output reg o_irq
);

   // Registers.
   reg [7:0] unit_control_q;
   reg [7:0] duty_write_q;
   reg [7:0] duty_shadow_q;
   reg [1:0] duty_lo_q;
   reg [7:0] periph_flags_q;
   reg [7:0] periph_flags_d;
   reg [7:0] periph_enables_q;
   reg [7:0] timer16_ctrl_q;
   reg [7:0] period_q;
   reg [7:0] timebase8_ctrl_q;
   reg [31:0] rdata_d;

   // Cycle enable and pin synchroniser.
   reg [1:0] osc_phase_q;
   reg ext_meta_q;
   reg ext_sync_q;
   reg ext_prev_q;

   // Compare state.
   reg cmp_equal_q;
   reg special_clear_q;
   reg roll_q;
   reg pwm_level_d;

   // Bus state.
   wire req = i_read || i_write;
   wire take = req && !o_waitrequest;
   wire wr_take = take && i_write;
   wire lane0 = i_byteenable[0];
   wire lane1 = i_byteenable[1];

   wire wr_unit_ctrl = wr_take && lane0 && (i_address == `CPW_OFF_UNIT_CTRL);
   wire wr_duty_write = wr_take && lane0 && (i_address == `CPW_OFF_DUTY_WRITE);
   wire wr_duty_shadow = wr_take && lane0 && (i_address == `CPW_OFF_DUTY_SHADOW);
   wire wr_flag_clear = wr_take && lane0 && (i_address == `CPW_OFF_FLAG_CLEAR);
   wire wr_enables = wr_take && lane0 && (i_address == `CPW_OFF_PERIPH_ENABLES);
   wire wr_t16_ctrl = wr_take && lane0 && (i_address == `CPW_OFF_TIMER16_CTRL);
   wire wr_t16_lo = wr_take && lane0 && (i_address == `CPW_OFF_TIMER16_COUNT);
   wire wr_t16_hi = wr_take && lane1 && (i_address == `CPW_OFF_TIMER16_COUNT);
   wire wr_period = wr_take && lane0 && (i_address == `CPW_OFF_PERIOD);
   wire wr_tb_count = wr_take && lane0 && (i_address == `CPW_OFF_TIMEBASE8_COUNT);
   wire wr_tb_ctrl = wr_take && lane0 && (i_address == `CPW_OFF_TIMEBASE8_CTRL);

   // Mode decode.
   wire [3:0] mode = unit_control_q[`CPW_CTRL_MODE_MSB:`CPW_CTRL_MODE_LSB];
   wire mode_pwm = (mode[3:2] == `CPW_MODE_PWM_MSB2);
   wire mode_swi = (mode == `CPW_MODE_CMP_SWI);
   wire mode_special = (mode == `CPW_MODE_CMP_SPECIAL);
   wire mode_compare = mode_swi || mode_special;

   // Sub-block outputs.
   wire [15:0] t16_count;
   wire t16_overflow;
   wire [7:0] tb_count;
   wire [1:0] tb_quarter;
   wire tb_rollover;

   // One instruction cycle spans four oscillator clocks.
   wire cycle_en = (osc_phase_q == (`CPW_OSC_PER_CYCLE - 1));
   wire ext_rise = ext_sync_q && !ext_prev_q;

   // The compare pair is the written byte low, the shadow byte high.
   wire [15:0] compare_value_pair = {duty_shadow_q, duty_write_q};
   wire cmp_equal = mode_compare && (t16_count == compare_value_pair);
   wire cmp_match = cmp_equal && !cmp_equal_q;

   // PWM duty: write register extended by the two control bits.
   wire [9:0] duty_next = {duty_write_q, unit_control_q[`CPW_CTRL_DUTY_LO_MSB:`CPW_CTRL_DUTY_LO_LSB]};
   wire [9:0] duty_latched = {duty_shadow_q, duty_lo_q};
   wire [9:0] tb_position = {tb_count, tb_quarter};

   always @(posedge i_clock) begin
      if (!i_resetn) begin
         osc_phase_q <= 2'h0;
      end else begin
         osc_phase_q <= osc_phase_q + 2'h1;
      end
   end

   // The first stage feeds only the second stage.
   always @(posedge i_clock) begin
      if (!i_resetn) begin
         ext_meta_q <= 1'b0;
         ext_sync_q <= 1'b0;
         ext_prev_q <= 1'b0;
      end else begin
         ext_meta_q <= i_t16_ext_clk;
         ext_sync_q <= ext_meta_q;
         ext_prev_q <= ext_sync_q;
      end
   end

   // The asynchronous select bit is stored but the count is always synchronous.
   cpw_timer16 #(
      .WIDTH(16)
   ) u_timer16 (
      .i_clock(i_clock),
      .i_resetn(i_resetn),
      .i_cycle_en(cycle_en),
      .i_ext_rise(ext_rise),
      .i_on(timer16_ctrl_q[`CPW_T16_ON]),
      .i_ext_sel(timer16_ctrl_q[`CPW_T16_EXT_SEL]),
      .i_prescale(timer16_ctrl_q[`CPW_T16_PRE_MSB:`CPW_T16_PRE_LSB]),
      .i_clear(special_clear_q),
      .i_wr_lo(wr_t16_lo),
      .i_wr_hi(wr_t16_hi),
      .i_wdata(i_writedata[15:0]),
      .o_count(t16_count),
      .o_overflow(t16_overflow)
   );

   cpw_timebase8 u_timebase8 (
      .i_clock(i_clock),
      .i_resetn(i_resetn),
      .i_on(timebase8_ctrl_q[`CPW_TB_ON]),
      .i_prescale(timebase8_ctrl_q[`CPW_TB_PRE_MSB:`CPW_TB_PRE_LSB]),
      .i_period(period_q),
      .i_wr_count(wr_tb_count),
      .i_wdata(i_writedata[7:0]),
      .o_count(tb_count),
      .o_quarter(tb_quarter),
      .o_rollover(tb_rollover)
   );

   // Software registers.
   always @(posedge i_clock) begin
      if (!i_resetn) begin
         unit_control_q <= `CPW_RST_UNIT_CTRL;
         duty_write_q <= `CPW_RST_DUTY;
         periph_enables_q <= `CPW_RST_PERIPH_ENABLES;
         timer16_ctrl_q <= `CPW_RST_TIMER16_CTRL;
         period_q <= `CPW_RST_PERIOD;
         timebase8_ctrl_q <= `CPW_RST_TIMEBASE8_CTRL;
      end else begin
         if (wr_unit_ctrl) begin
            unit_control_q <= i_writedata[7:0];
         end
         if (wr_duty_write) begin
            duty_write_q <= i_writedata[7:0];
         end
         if (wr_enables) begin
            periph_enables_q <= i_writedata[7:0] & `CPW_FLAG_MASK;
         end
         if (wr_t16_ctrl) begin
            timer16_ctrl_q <= i_writedata[7:0] & `CPW_T16_CTRL_MASK;
         end
         if (wr_period) begin
            period_q <= i_writedata[7:0];
         end
         if (wr_tb_ctrl) begin
            timebase8_ctrl_q <= i_writedata[7:0] & `CPW_TB_CTRL_MASK;
         end
      end
   end

   // Shadow duty: software-writable high compare byte, read-only in PWM.
   always @(posedge i_clock) begin
      if (!i_resetn) begin
         duty_shadow_q <= `CPW_RST_DUTY;
         duty_lo_q <= 2'h0;
      end else if (mode_pwm) begin
         if (tb_rollover) begin
            duty_shadow_q <= duty_next[9:2];
            duty_lo_q <= duty_next[1:0];
         end
      end else if (wr_duty_shadow) begin
         duty_shadow_q <= i_writedata[7:0];
      end
   end

   // Compare match detection and special event trigger.
   always @(posedge i_clock) begin
      if (!i_resetn) begin
         cmp_equal_q <= 1'b0;
         special_clear_q <= 1'b0;
         o_adc_start <= 1'b0;
      end else begin
         cmp_equal_q <= cmp_equal;
         // The clear replaces the next timer increment, so the count runs from zero to the pair.
         special_clear_q <= cmp_match && mode_special;
         o_adc_start <= cmp_match && mode_special;
      end
   end

   // The pin rises one clock after the rollover, so the high time is exactly the duty time.
   always @(posedge i_clock) begin
      if (!i_resetn) begin
         roll_q <= 1'b0;
      end else begin
         roll_q <= tb_rollover;
      end
   end

   // PWM output latch; compare modes leave it alone.
   always @* begin
      pwm_level_d = o_unit_pin;
      if (mode_pwm) begin
         if (roll_q) begin
            pwm_level_d = (duty_latched != 10'h000);
         end else if (tb_position == duty_latched) begin
            pwm_level_d = 1'b0;
         end
      end
   end

   always @(posedge i_clock) begin
      if (!i_resetn) begin
         o_unit_pin <= 1'b0;
      end else if (wr_unit_ctrl && (i_writedata[7:0] == 8'h00)) begin
         o_unit_pin <= 1'b0;
      end else begin
         o_unit_pin <= pwm_level_d;
      end
   end

   // Sticky flags: a hardware set wins over a clear in the same cycle.
   always @* begin
      periph_flags_d = periph_flags_q;
      if (wr_flag_clear) begin
         periph_flags_d = periph_flags_d & ~i_writedata[7:0];
      end
      if (t16_overflow) begin
         periph_flags_d[`CPW_FLAG_TIMER16_OVF] = 1'b1;
      end
      if (tb_rollover) begin
         periph_flags_d[`CPW_FLAG_TIMEBASE8_MATCH] = 1'b1;
      end
      if (cmp_match) begin
         periph_flags_d[`CPW_FLAG_UNIT_EVENT] = 1'b1;
      end
   end

   always @(posedge i_clock) begin
      if (!i_resetn) begin
         periph_flags_q <= `CPW_RST_PERIPH_FLAGS;
         o_irq <= 1'b0;
      end else begin
         periph_flags_q <= periph_flags_d & `CPW_FLAG_MASK;
         o_irq <= |(periph_flags_d & periph_enables_q);
      end
   end

   // Read mux; unmapped and write-only addresses read as zero.
   always @* begin
      rdata_d = 32'h00000000;
      case (i_address)
         `CPW_OFF_UNIT_CTRL: rdata_d[7:0] = unit_control_q;
         `CPW_OFF_DUTY_WRITE: rdata_d[7:0] = duty_write_q;
         `CPW_OFF_DUTY_SHADOW: rdata_d[7:0] = duty_shadow_q;
         `CPW_OFF_PERIPH_FLAGS: rdata_d[7:0] = periph_flags_q;
         `CPW_OFF_TIMER16_CTRL: rdata_d[7:0] = timer16_ctrl_q;
         `CPW_OFF_TIMER16_COUNT: rdata_d[15:0] = t16_count;
         `CPW_OFF_PERIOD: rdata_d[7:0] = period_q;
         `CPW_OFF_TIMEBASE8_COUNT: rdata_d[7:0] = tb_count;
         `CPW_OFF_TIMEBASE8_CTRL: rdata_d[7:0] = timebase8_ctrl_q;
         `CPW_OFF_PERIPH_ENABLES: rdata_d[7:0] = periph_enables_q;
         default: rdata_d = 32'h00000000;
      endcase
   end

   // One wait cycle per access; read data lands as waitrequest drops, write effects one edge later.
   always @(posedge i_clock) begin
      if (!i_resetn) begin
         o_waitrequest <= 1'b1;
         o_readdata <= 32'h00000000;
      end else begin
         o_waitrequest <= !(req && o_waitrequest);
         if (req && o_waitrequest && i_read) begin
            o_readdata <= rdata_d;
         end
      end
   end

endmodule

`default_nettype wire

// [sim/cpw_unit_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module cpw_unit_chk (
   // Clock and reset.
   input wire logic i_clock,
   input wire logic i_resetn,
   // Register bus.
   input wire logic [7:0] i_address,
   input wire logic i_read,
   input wire logic i_write,
   input wire logic [3:0] i_byteenable,
   input wire logic [31:0] i_writedata,
   input wire logic [31:0] o_readdata,
   input wire logic o_waitrequest,
   // Unit outputs.
   input wire logic o_unit_pin,
   input wire logic o_adc_start,
   input wire logic o_irq
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_resetn);
   logic [3:0] mode_q;
   logic [7:0] en_q;
   wire wr_done = i_write && !o_waitrequest && i_byteenable[0];
   // Mirrors of the mode and enable registers, taken from completed writes.
   always @(posedge i_clock) begin
      if (!i_resetn) begin
         mode_q <= 4'h0;
         en_q <= 8'h00;
      end else if (wr_done) begin
         if (i_address == 8'h00) mode_q <= i_writedata[3:0];
         if (i_address == 8'h8C) en_q <= i_writedata[7:0];
      end
   end
   a_wait_once: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
      else $error("access not answered after one wait cycle");
   a_wait_pulse: assert property (!o_waitrequest |=> o_waitrequest)
      else $error("waitrequest low for more than one cycle");
   a_wait_idle: assert property (!(i_read || i_write) |=> o_waitrequest)
      else $error("waitrequest low without a request");
   a_clear_reads_zero: assert property (i_read && !o_waitrequest && (i_address == 8'h24 || i_address == 8'h40)
      |-> o_readdata == 32'h0)
      else $error("clear or unmapped place read nonzero");
   a_ctrl_zero_low: assert property (wr_done && i_address == 8'h00 && i_writedata[7:0] == 8'h00 |=> !o_unit_pin)
      else $error("pin not low after control cleared");
   a_adc_mode_only: assert property (o_adc_start |-> $past(mode_q) == 4'hB)
      else $error("conversion start outside special event mode");
   a_adc_spacing: assert property (o_adc_start |=> !o_adc_start [*3])
      else $error("conversion starts closer than one timer tick");
   a_swi_pin_still: assert property (mode_q == 4'hA && $past(mode_q) == 4'hA |-> $stable(o_unit_pin))
      else $error("pin moved in software interrupt mode");
   a_irq_masked: assert property (en_q == 8'h00 && $past(en_q) == 8'h00 && $past(en_q, 2) == 8'h00 |-> !o_irq)
      else $error("interrupt raised with all enables off");
endmodule
bind cpw_unit cpw_unit_chk cpw_unit_chk_i (.i_clock(i_clock), .i_resetn(i_resetn), .i_address(i_address),
   .i_read(i_read), .i_write(i_write), .i_byteenable(i_byteenable), .i_writedata(i_writedata),
   .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .o_unit_pin(o_unit_pin),
   .o_adc_start(o_adc_start), .o_irq(o_irq));
`default_nettype wire

// [sim/cpw_load_model.sv]
`timescale 1ns/1ps
`default_nettype none
module cpw_load_model (
   // Clock.
   input wire logic i_clock,
   // Pin, port direction and conversion start.
   input wire logic i_pin,
   input wire logic i_dir_out,
   input wire logic i_adc_start,
   // Measured lengths in clocks.
   output logic [15:0] o_high = 16'h0,
   output logic [15:0] o_period = 16'h0,
   output logic [15:0] o_start_gap = 16'h0
);
   logic last_q = 1'b0;
   logic [15:0] rise_cnt_q = 16'h0;
   logic [15:0] high_cnt_q = 16'h0;
   logic [15:0] gap_cnt_q = 16'h0;
   // The load pulls the line low, so a pin left as input reads low.
   wire seen = i_dir_out & i_pin;
   always @(posedge i_clock) begin
      last_q <= seen;
      rise_cnt_q <= rise_cnt_q + 16'h1;
      high_cnt_q <= high_cnt_q + {15'h0, seen};
      gap_cnt_q <= gap_cnt_q + 16'h1;
      if (seen && !last_q) begin
         o_period <= rise_cnt_q;
         rise_cnt_q <= 16'h1;
         high_cnt_q <= 16'h1;
      end
      if (!seen && last_q) o_high <= high_cnt_q;
      if (i_adc_start) begin
         o_start_gap <= gap_cnt_q;
         gap_cnt_q <= 16'h1;
      end
   end
endmodule
`default_nettype wire

// [sim/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic i_clock = 1'b0;
   logic i_resetn = 1'b0;
   logic [7:0] i_address = 8'h00;
   logic i_read = 1'b0;
   logic i_write = 1'b0;
   logic [3:0] i_byteenable = 4'h0;
   logic [31:0] i_writedata = 32'h0;
   logic i_t16_ext_clk = 1'b0;
   logic pin_dir_out = 1'b1;
   wire [31:0] o_readdata;
   wire o_waitrequest, o_unit_pin, o_adc_start, o_irq;
   wire [15:0] high_len, period_len, start_gap;
   int n_mismatch = 0;
   int total_checks = 0;
   int seed = 41;
   int v, p, d, pre;
   logic [31:0] rdata;
   logic saw;
   logic [7:0] ra [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18, 8'h20, 8'h24, 8'h8C, 8'h40};
   cpw_unit cpw_unit_i (.i_clock(i_clock), .i_resetn(i_resetn), .i_address(i_address), .i_read(i_read),
      .i_write(i_write), .i_byteenable(i_byteenable), .i_writedata(i_writedata), .o_readdata(o_readdata),
      .o_waitrequest(o_waitrequest), .i_t16_ext_clk(i_t16_ext_clk), .o_unit_pin(o_unit_pin),
      .o_adc_start(o_adc_start), .o_irq(o_irq));
   cpw_load_model cpw_load_model_i (.i_clock(i_clock), .i_pin(o_unit_pin), .i_dir_out(pin_dir_out),
      .i_adc_start(o_adc_start), .o_high(high_len), .o_period(period_len), .o_start_gap(start_gap));
   initial forever #2 i_clock = ~i_clock;
   function automatic int pwm_period(int per, int ps);
      return (per + 1) * 4 * ps;
   endfunction
   function automatic int cmp_gap(int val);
      return (val + 1) * 4;
   endfunction
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge i_clock);
      i_address <= a;
      i_writedata <= wd;
      i_byteenable <= 4'hF;
      i_write <= wr;
      i_read <= !wr;
      do begin
         @(posedge i_clock);
         n++;
      end while (o_waitrequest !== 1'b0 && n < 50);
      rdata = o_readdata;
      i_write <= 1'b0;
      i_read <= 1'b0;
      chk("waitrequest", 32'h0, 32'(o_waitrequest));
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] wd);
      bus(1'b1, a, wd);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk($sformatf("register %h", a), exp, rdata);
   endtask
   task automatic test_done;
      $display("checks %0d, mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (80000) @(posedge i_clock);
      n_mismatch++;
      $display("unexpected run length: expected end of tests, seen timeout");
      test_done();
   end
   initial begin
      repeat (4) @(posedge i_clock);
      i_resetn <= 1'b1;
      foreach (ra[k]) rd(ra[k], ra[k] == 8'h18 ? 32'hFF : 32'h0);
      wr(8'h0C, 32'hFF);
      rd(8'h0C, 32'h0);
      wr(8'h10, 32'hFF);
      rd(8'h10, 32'h37);
      wr(8'h10, 32'h0);
      wr(8'h14, 32'hA5C3);
      rd(8'h14, 32'hA5C3);
      wr(8'h10, 32'h03);
      v = 1 + $unsigned($random(seed)) % 20;
      repeat (v) begin
         repeat (4) @(posedge i_clock);
         i_t16_ext_clk <= 1'b1;
         repeat (4) @(posedge i_clock);
         i_t16_ext_clk <= 1'b0;
      end
      repeat (4) @(posedge i_clock);
      wr(8'h10, 32'h0);
      rd(8'h14, 32'hA5C3 + v);
      $display("test registers done");
      for (int c = 0; c < 3; c++) begin
         pre = c == 0 ? 1 : (c == 1 ? 4 : 16);
         p = 3 + $unsigned($random(seed)) % 18;
         d = c == 0 ? 4 * p : 1 + $unsigned($random(seed)) % (4 * p);
         wr(8'h18, p);
         wr(8'h1C, 32'h0);
         wr(8'h04, d >> 2);
         wr(8'h00, 32'h0C + c + ((d & 3) << 4));
         wr(8'h20, 32'h04 | c);
         repeat (3 * pwm_period(p, pre) + 8) @(posedge i_clock);
         chk("pwm period", pwm_period(p, pre), {16'h0, period_len});
         chk("pwm high time", d * pre, {16'h0, high_len});
         wr(8'h08, 32'h5A);
         rd(8'h08, d >> 2);
      end
      wr(8'h04, 32'h0);
      wr(8'h00, 32'h0F);
      repeat (2 * pwm_period(p, pre)) @(posedge i_clock);
      saw = 1'b0;
      repeat (pwm_period(p, pre)) begin
         @(posedge i_clock);
         saw = saw | o_unit_pin;
      end
      chk("pin at zero duty", 32'h0, 32'(saw));
      wr(8'h04, p);
      wr(8'h00, 32'h0C);
      repeat (pwm_period(p, pre)) @(posedge i_clock);
      while (o_unit_pin !== 1'b1) @(posedge i_clock);
      chk("pin before control clear", 32'h1, 32'(o_unit_pin));
      wr(8'h00, 32'h0);
      @(posedge i_clock);
      chk("pin after control clear", 32'h0, 32'(o_unit_pin));
      $display("test pwm done");
      for (int m = 10; m < 12; m++) begin
         v = 8 + $unsigned($random(seed)) % 33;
         wr(8'h10, 32'h0);
         wr(8'h14, 32'h0);
         wr(8'h04, v);
         wr(8'h08, 32'h0);
         wr(8'h00, m);
         wr(8'h24, 32'h07);
         wr(8'h8C, m == 10 ? 32'h04 : 32'h01);
         wr(8'h10, 32'h01);
         repeat (3 * cmp_gap(v) + 12) @(posedge i_clock);
         bus(1'b0, 8'h0C, 32'h0);
         chk("overflow flag", 32'h0, 32'(rdata[0]));
         chk("interrupt", 32'(m == 10), 32'(o_irq));
         chk("pin in compare", 32'h0, 32'(o_unit_pin));
         if (m == 11) chk("trigger gap", cmp_gap(v), {16'h0, start_gap});
         wr(8'h24, 32'h07);
         repeat (2) @(posedge i_clock);
         chk("interrupt after clear", 32'h0, 32'(o_irq));
      end
      $display("test compare done");
      test_done();
   end
endmodule
`default_nettype wire
